/* hw/rcs_ref_switch.sv */
`timescale 1ns/1ps
// Reference selection, switchover, PLL divider setup and shutdown pin
module rcs_ref_switch
   import rcs_pkg::*;
#(
   parameter logic [6:0] DEV_ADDR = 7'h6a, // Arbitrary device address
   parameter int LOSS_CYCLES = 2 // Secondary cycles with a silent primary before switchover
)
(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   input wire logic crystal_or_ref_input,
   input wire logic clock_only_input,
   input wire logic input_select_pin,
   input wire logic shutdown_output_enable_pin,
   output logic ref_clk_out,
   output logic secondary_in_use,
   output logic outputs_enabled,
   output logic chip_power_down,
   output logic [2:0] pll_power_down,
   output logic [6:0] pll0_prediv,
   output logic [6:0] pll1_prediv,
   output logic [6:0] pll2_prediv,
   output logic [6:0] pll3_prediv,
   output logic [13:0] pll0_mult,
   output logic [11:0] pll1_mult,
   output logic [11:0] pll2_mult,
   output logic [11:0] pll3_mult,
   output logic [5:0] load_cap_eighths,
   output logic [7:0] crystal_drive,
   output logic [1:0] config_error
);
   // Parameter check
   if (LOSS_CYCLES < 1 || LOSS_CYCLES > 3)
      $error("LOSS_CYCLES must be 1 to 3");

   localparam logic [1:0] LOSS_LIMIT = 2'(LOSS_CYCLES);

   logic wr_stb; // Register write strobe
   logic [7:0] reg_addr; // Register pointer
   logic [7:0] wr_data; // Write byte
   logic [7:0] rd_data; // Read byte
   logic [7:0] sd_cfg_ff; // Shutdown pin setup
   logic [7:0] src_cfg_ff; // Primary and mode
   logic [4:0] crystal_load_code_ff; // Load code
   logic [6:0] prediv_ff [PLL_COUNT]; // Pre-dividers
   logic [11:0] fb_ff [PLL_COUNT]; // Feedback counts
   logic [3:0] frac_ff; // Fractional count, first PLL
   logic xin_q_ff; // Input samples and history
   logic clock_only_input_q_ff;
   logic prim_prev_ff;
   logic sec_prev_ff;
   logic [1:0] miss_cnt_ff; // Secondary cycles without primary edge
   logic use_sec_ff; // Selection in force
   logic primary_source_bit; // Decoded fields
   logic [1:0] switchover_mode_field;
   logic prim_c;
   logic sec_c;
   logic want_sec_c;
   logic [11:0] mult_ff [1:3]; // Integer multipliers

   // Alias window for the source register
   function automatic logic is_src(input logic [7:0] a);
      is_src = (a >= ADR_SRC_FIRST) && (a <= ADR_SRC_LAST);
   endfunction

   rcs_i2c_port #(.DEV_ADDR(DEV_ADDR)) u_port
   (
      .core_clk(core_clk),
      .rst(rst),
      .ce(ce),
      .scl_in(scl_in),
      .sda_in(sda_in),
      .sda_out(sda_out),
      .sda_oe(sda_oe),
      .wr_stb(wr_stb),
      .reg_addr(reg_addr),
      .wr_data(wr_data),
      .rd_data(rd_data)
   );

   assign primary_source_bit = src_cfg_ff[SRC_PRIM_BIT];
   assign switchover_mode_field = src_cfg_ff[SRC_MODE_MSB:SRC_MODE_LSB];

   // Register writes
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         sd_cfg_ff <= SD_CFG_RST;
         crystal_drive <= CRYSTAL_DRIVE_CFG_RST;
         crystal_load_code_ff <= XLOAD_RST;
         src_cfg_ff <= SRC_RST;
         frac_ff <= FRAC_RST;
         for (int i = 0; i < PLL_COUNT; i++)
         begin
            prediv_ff[i] <= (i == PLL_COUNT - 1) ? PREDIV3_RST : PREDIV_RST;
            fb_ff[i] <= FB_RST;
         end
      end
      else if (ce && wr_stb)
      begin
         if (reg_addr == ADR_SD_CFG)
            sd_cfg_ff <= wr_data;
         if (reg_addr == ADR_CRYSTAL_DRIVE_CFG)
            crystal_drive <= wr_data;
         if (reg_addr == ADR_XLOAD)
            crystal_load_code_ff <= wr_data[4:0];
         if (is_src(reg_addr))
            src_cfg_ff <= wr_data;
         if (reg_addr == ADR_FRAC)
            frac_ff <= wr_data[3:0];
         for (int i = 0; i < PLL_COUNT; i++)
         begin
            if (reg_addr == ADR_PREDIV_BASE + 8'(i))
               prediv_ff[i] <= wr_data[6:0];
            if (reg_addr == ADR_FBLO_BASE + 8'(i))
               fb_ff[i][7:0] <= wr_data;
            if (reg_addr == ADR_FBHI_BASE + 8'(i))
               fb_ff[i][11:8] <= wr_data[3:0];
         end
      end
   end

   // Register reads, unmapped offsets read zero
   always_comb
   begin
      rd_data = 8'h00;
      if (reg_addr == ADR_SD_CFG)
         rd_data = sd_cfg_ff;
      else if (reg_addr == ADR_CRYSTAL_DRIVE_CFG)
         rd_data = crystal_drive;
      else if (reg_addr == ADR_XLOAD)
         rd_data = {3'h0, crystal_load_code_ff};
      else if (is_src(reg_addr))
         rd_data = src_cfg_ff;
      else if (reg_addr == ADR_FRAC)
         rd_data = {4'h0, frac_ff};
      else if (reg_addr == ADR_STATUS)
         rd_data = {4'h0, config_error, miss_cnt_ff == LOSS_LIMIT, use_sec_ff};
      for (int i = 0; i < PLL_COUNT; i++)
      begin
         if (reg_addr == ADR_PREDIV_BASE + 8'(i))
            rd_data = {1'b0, prediv_ff[i]};
         if (reg_addr == ADR_FBLO_BASE + 8'(i))
            rd_data = fb_ff[i][7:0];
         if (reg_addr == ADR_FBHI_BASE + 8'(i))
            rd_data = {4'h0, fb_ff[i][11:8]};
      end
   end

   // Primary and secondary roles
   always_comb
   begin
      prim_c = primary_source_bit ? clock_only_input_q_ff : xin_q_ff;
      sec_c = primary_source_bit ? xin_q_ff : clock_only_input_q_ff;
   end

   // Reference sampling and edge history
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         xin_q_ff <= 1'b0;
         clock_only_input_q_ff <= 1'b0;
         prim_prev_ff <= 1'b0;
         sec_prev_ff <= 1'b0;
      end
      else if (ce)
      begin
         xin_q_ff <= crystal_or_ref_input;
         clock_only_input_q_ff <= clock_only_input;
         prim_prev_ff <= prim_c;
         sec_prev_ff <= sec_c;
      end
   end

   // Secondary cycles seen since last primary transition
   always_ff @(posedge core_clk)
   begin
      if (rst)
         miss_cnt_ff <= 2'h0;
      else if (ce)
      begin
         if (prim_c != prim_prev_ff)
            miss_cnt_ff <= 2'h0;
         else if (sec_c && !sec_prev_ff && miss_cnt_ff != LOSS_LIMIT)
            miss_cnt_ff <= miss_cnt_ff + 2'h1;
      end
   end

   // Wanted source: pin in manual, loss detector in automatic
   always_comb
   begin
      if (switchover_mode_field[1])
         want_sec_c = (miss_cnt_ff == LOSS_LIMIT);
      else
         want_sec_c = input_select_pin;
   end

   // Source selection and routed reference
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         use_sec_ff <= 1'b0;
         ref_clk_out <= 1'b0;
         secondary_in_use <= 1'b0;
      end
      else if (ce)
      begin
         if (switchover_mode_field[1])
            use_sec_ff <= want_sec_c; // Immediate, pulses tolerated
         else if (!prim_c && !sec_c)
            use_sec_ff <= want_sec_c; // Switch while both low, no glitch
         ref_clk_out <= use_sec_ff ? sec_c : prim_c;
         secondary_in_use <= use_sec_ff;
      end
   end

   // Shutdown pin decode
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         outputs_enabled <= 1'b1;
         chip_power_down <= 1'b0;
      end
      else if (ce)
      begin
         if (shutdown_output_enable_pin == sd_cfg_ff[SD_POL_BIT])
         begin
            outputs_enabled <= 1'b0;
            chip_power_down <= sd_cfg_ff[SD_PDMODE_BIT];
         end
         else
         begin
            outputs_enabled <= 1'b1;
            chip_power_down <= 1'b0;
         end
      end
   end

   // First PLL multiplier, dividers and checks
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         pll0_mult <= {1'b0, FB_RST, 1'b0};
         pll0_prediv <= PREDIV_RST;
         pll1_prediv <= PREDIV_RST;
         pll2_prediv <= PREDIV_RST;
         pll3_prediv <= PREDIV3_RST;
         load_cap_eighths <= LOAD_BASE_EIGHTHS;
         config_error <= 2'h0;
      end
      else if (ce)
      begin
         if (frac_ff != FRAC_RST)
            pll0_mult <= {1'b0, fb_ff[0], 1'b0} + {10'h000, frac_ff} + 14'h0001;
         else
            pll0_mult <= {1'b0, fb_ff[0], 1'b0};
         pll0_prediv <= prediv_ff[0];
         pll1_prediv <= prediv_ff[1];
         pll2_prediv <= prediv_ff[2];
         pll3_prediv <= prediv_ff[3];
         load_cap_eighths <= LOAD_BASE_EIGHTHS + {1'b0, crystal_load_code_ff};
         config_error[0] <= ({8'h00, frac_ff} >= fb_ff[0]) && (frac_ff != FRAC_RST);
         config_error[1] <= prediv_ff[3] < PLL3_PREDIV_MIN;
      end
   end

   // Power down on zero pre-divider, first three PLLs
   generate
      for (genvar g = 0; g < PLL_PD_COUNT; g++)
      begin : g_pd
         always_ff @(posedge core_clk)
         begin
            if (rst)
               pll_power_down[g] <= 1'b0;
            else if (ce)
               pll_power_down[g] <= (prediv_ff[g] == PREDIV_OFF);
         end
      end
   endgenerate

   // Integer multipliers follow the feedback count
   generate
      for (genvar g = 1; g < PLL_COUNT; g++)
      begin : g_mult
         always_ff @(posedge core_clk)
         begin
            if (rst)
               mult_ff[g] <= FB_RST;
            else if (ce)
               mult_ff[g] <= fb_ff[g];
         end
      end
   endgenerate

   assign pll1_mult = mult_ff[1];
   assign pll2_mult = mult_ff[2];
   assign pll3_mult = mult_ff[3];
endmodule

/* pkg/rcs_pkg.sv */
package rcs_pkg;
   // Register offsets
   localparam logic [7:0] ADR_SD_CFG = 8'h02;
   localparam logic [7:0] ADR_CRYSTAL_DRIVE_CFG = 8'h06;
   localparam logic [7:0] ADR_XLOAD = 8'h07;
   localparam logic [7:0] ADR_SRC_FIRST = 8'hbe;
   localparam logic [7:0] ADR_SRC_LAST = 8'hc3;
   localparam logic [7:0] ADR_PREDIV_BASE = 8'h10;
   localparam logic [7:0] ADR_FBLO_BASE = 8'h14;
   localparam logic [7:0] ADR_FBHI_BASE = 8'h18;
   localparam logic [7:0] ADR_FRAC = 8'h1c;
   localparam logic [7:0] ADR_STATUS = 8'h20;
   // Field positions
   localparam int SD_POL_BIT = 0;
   localparam int SD_PDMODE_BIT = 1;
   localparam int SRC_PRIM_BIT = 0;
   localparam int SRC_MODE_LSB = 1;
   localparam int SRC_MODE_MSB = 2;
   // Reset values
   localparam logic [7:0] SD_CFG_RST = 8'h00;
   localparam logic [7:0] CRYSTAL_DRIVE_CFG_RST = 8'h11;
   localparam logic [4:0] XLOAD_RST = 5'h00;
   localparam logic [7:0] SRC_RST = 8'h00;
   localparam logic [6:0] PREDIV_RST = 7'h01;
   localparam logic [6:0] PREDIV3_RST = 7'h03;
   localparam logic [11:0] FB_RST = 12'h005;
   localparam logic [3:0] FRAC_RST = 4'h0;
   // Limits and scale
   localparam logic [6:0] PREDIV_OFF = 7'h00;
   localparam logic [6:0] PLL3_PREDIV_MIN = 7'h03;
   localparam logic [5:0] LOAD_BASE_EIGHTHS = 6'h1c;
   localparam int PLL_COUNT = 4;
   localparam int PLL_PD_COUNT = 3;
endpackage

/* hw/rcs_i2c_port.sv */
`timescale 1ns/1ps
// Byte-oriented serial register port: pointer write, data write, data read
module rcs_i2c_port
   import rcs_pkg::*;
#(
   parameter logic [6:0] DEV_ADDR = 7'h6a // Arbitrary device address
)
(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   output logic wr_stb,
   output logic [7:0] reg_addr,
   output logic [7:0] wr_data,
   input wire logic [7:0] rd_data
);
   typedef enum logic [4:0]
   {
      ST_IDLE = 5'b0_0001,
      ST_DEV = 5'b0_0010,
      ST_PTR = 5'b0_0100,
      ST_WR = 5'b0_1000,
      ST_RD = 5'b1_0000
   } rcs_i2c_state_t;

   rcs_i2c_state_t state_ff; // Transfer phase
   logic scl_q_ff; // Previous line samples
   logic sda_q_ff;
   logic [3:0] bit_cnt_ff; // 0..7 data, 8 ack, 9 ack held
   logic [7:0] shift_ff; // Byte shifter
   logic rw_ff; // Read transfer
   logic start_c; // Line events
   logic stop_c;
   logic rise_c;
   logic fall_c;

   assign start_c = scl_q_ff & scl_in & sda_q_ff & ~sda_in;
   assign stop_c = scl_q_ff & scl_in & ~sda_q_ff & sda_in;
   assign rise_c = ~scl_q_ff & scl_in;
   assign fall_c = scl_q_ff & ~scl_in;

   // Line history for edge detection
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         scl_q_ff <= 1'b1;
         sda_q_ff <= 1'b1;
      end
      else if (ce)
      begin
         scl_q_ff <= scl_in;
         sda_q_ff <= sda_in;
      end
   end

   // Data line is only ever pulled low
   always_ff @(posedge core_clk)
   begin
      sda_out <= 1'b0;
   end

   // Transfer engine
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         state_ff <= ST_IDLE;
         bit_cnt_ff <= 4'h0;
         shift_ff <= 8'h00;
         rw_ff <= 1'b0;
         sda_oe <= 1'b0;
         wr_stb <= 1'b0;
         reg_addr <= 8'h00;
         wr_data <= 8'h00;
      end
      else if (ce)
      begin
         wr_stb <= 1'b0;
         if (start_c)
         begin
            // Start or repeated start
            state_ff <= ST_DEV;
            bit_cnt_ff <= 4'h0;
            sda_oe <= 1'b0;
         end
         else if (stop_c)
         begin
            state_ff <= ST_IDLE;
            sda_oe <= 1'b0;
         end
         else if (rise_c)
         begin
            case (state_ff)
               ST_DEV, ST_PTR, ST_WR:
               begin
                  // Receive a bit
                  if (bit_cnt_ff < 4'h8)
                  begin
                     shift_ff <= {shift_ff[6:0], sda_in};
                     bit_cnt_ff <= bit_cnt_ff + 4'h1;
                  end
               end
               ST_RD:
               begin
                  // Master acknowledge slot
                  if (bit_cnt_ff == 4'h8)
                  begin
                     if (sda_in)
                        state_ff <= ST_IDLE;
                     else
                        reg_addr <= reg_addr + 8'h01;
                  end
                  bit_cnt_ff <= bit_cnt_ff + 4'h1;
               end
               default:
                  bit_cnt_ff <= bit_cnt_ff;
            endcase
         end
         else if (fall_c)
         begin
            case (state_ff)
               ST_DEV, ST_PTR, ST_WR:
               begin
                  if (bit_cnt_ff == 4'h8)
                  begin
                     // Byte complete, decide acknowledge
                     bit_cnt_ff <= 4'h9;
                     sda_oe <= 1'b1;
                     if (state_ff == ST_DEV && shift_ff[7:1] != DEV_ADDR)
                     begin
                        state_ff <= ST_IDLE;
                        sda_oe <= 1'b0;
                     end
                     else if (state_ff == ST_DEV)
                        rw_ff <= shift_ff[0];
                     else if (state_ff == ST_PTR)
                        reg_addr <= shift_ff;
                     else
                     begin
                        wr_stb <= 1'b1;
                        wr_data <= shift_ff;
                     end
                  end
                  else if (bit_cnt_ff == 4'h9)
                  begin
                     // Acknowledge done, next phase
                     bit_cnt_ff <= 4'h0;
                     sda_oe <= 1'b0;
                     if (state_ff == ST_DEV && rw_ff)
                     begin
                        state_ff <= ST_RD;
                        shift_ff <= rd_data;
                        sda_oe <= ~rd_data[7];
                     end
                     else if (state_ff == ST_DEV)
                        state_ff <= ST_PTR;
                     else if (state_ff == ST_PTR)
                        state_ff <= ST_WR;
                     else
                        reg_addr <= reg_addr + 8'h01;
                  end
               end
               ST_RD:
               begin
                  if (bit_cnt_ff < 4'h8)
                  begin
                     // Present next data bit
                     shift_ff <= {shift_ff[6:0], 1'b0};
                     sda_oe <= ~shift_ff[6];
                  end
                  else if (bit_cnt_ff == 4'h8)
                     sda_oe <= 1'b0;
                  else
                  begin
                     // Reload for the following byte
                     bit_cnt_ff <= 4'h0;
                     shift_ff <= rd_data;
                     sda_oe <= ~rd_data[7];
                  end
               end
               default:
                  sda_oe <= 1'b0;
            endcase
         end
      end
   end
endmodule

/* tb/rcs_ref_switch_monitor.sv */
`timescale 1ns/1ps
// Port-level checks beside the reference switch block
module rcs_ref_switch_monitor
   import rcs_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic scl_in,
   input wire logic crystal_or_ref_input,
   input wire logic clock_only_input,
   input wire logic sda_out,
   input wire logic sda_oe,
   input wire logic ref_clk_out,
   input wire logic outputs_enabled,
   input wire logic chip_power_down,
   input wire logic [2:0] pll_power_down,
   input wire logic [6:0] pll0_prediv,
   input wire logic [6:0] pll1_prediv,
   input wire logic [6:0] pll2_prediv,
   input wire logic [6:0] pll3_prediv,
   input wire logic [5:0] load_cap_eighths,
   input wire logic [1:0] config_error
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   // First three pre-dividers settled for two edges
   sequence s_preds_steady;
      $stable({pll0_prediv, pll1_prediv, pll2_prediv})[*2];
   endsequence
   // Both references quiet long enough to flush the sample path
   sequence s_refs_quiet;
      (!crystal_or_ref_input && !clock_only_input)[*4];
   endsequence
   a_sda_open_drain: assert property (sda_out == 1'b0)
      else $error("data line driven high");
   a_pd_from_prediv: assert property (s_preds_steady |-> pll_power_down ==
      {pll2_prediv == PREDIV_OFF, pll1_prediv == PREDIV_OFF, pll0_prediv == PREDIV_OFF})
      else $error("power down does not match zero pre-divider");
   a_pll3_limit: assert property ($stable(pll3_prediv)[*2] |->
      config_error[1] == (pll3_prediv < PLL3_PREDIV_MIN))
      else $error("fourth pre-divider error flag wrong");
   a_load_span: assert property (load_cap_eighths >= LOAD_BASE_EIGHTHS &&
      load_cap_eighths <= LOAD_BASE_EIGHTHS + 6'd31)
      else $error("load capacitance out of span");
   a_pd_disables: assert property (chip_power_down |-> !outputs_enabled)
      else $error("power down with outputs enabled");
   a_ref_quiet: assert property (s_refs_quiet |-> !ref_clk_out)
      else $error("reference output moves with quiet inputs");
   a_ack_scl_low: assert property ($rose(sda_oe) |-> !$past(scl_in))
      else $error("data driven while clock high");
   a_oe_release_low: assert property ($fell(sda_oe) |-> !$past(scl_in))
      else $error("data released while clock high");
endmodule

bind rcs_ref_switch rcs_ref_switch_monitor mon_u (.core_clk, .rst, .scl_in, .crystal_or_ref_input,
   .clock_only_input, .sda_out, .sda_oe, .ref_clk_out, .outputs_enabled, .chip_power_down, .pll_power_down,
   .pll0_prediv, .pll1_prediv, .pll2_prediv, .pll3_prediv, .load_cap_eighths, .config_error);

/* tb/rcs_ref_model.sv */
`timescale 1ns/1ps
// Two stoppable reference sources; a stopped one holds its level
module rcs_ref_model
(
   input wire logic core_clk,
   input wire logic run_ref,
   input wire logic run_clk,
   output logic ref_line,
   output logic clk_line
);
   logic [1:0] div_ff = 2'h0; // Shared phase counter
   initial ref_line = 1'b0;
   initial clk_line = 1'b0;
   // Clock line runs at half the reference line rate
   always @(posedge core_clk)
   begin
      div_ff <= div_ff + 2'h1;
      if (run_ref && div_ff[0])
         ref_line <= ~ref_line;
      if (run_clk && div_ff == 2'h3)
         clk_line <= ~clk_line;
   end
endmodule

/* tb/tb.sv */
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin samples_checked++; if ((gt) !== (ex)) begin error_cnt++; \
   $display("[ERR] %s exp %0h got %0h", nm, ex, gt); end end
module tb;
   import rcs_pkg::*;
   localparam logic [6:0] DEV = 7'h6a; // Arbitrary device address
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic ce = 1'b1;
   logic scl_in = 1'b1;
   logic host_sda = 1'b1;
   logic input_select_pin = 1'b0;
   logic shutdown_output_enable_pin = 1'b0;
   logic run_ref = 1'b1;
   logic run_clk = 1'b1;
   logic sda_out, sda_oe, crystal_or_ref_input, clock_only_input, ref_clk_out, secondary_in_use;
   logic outputs_enabled, chip_power_down;
   logic [2:0] pll_power_down;
   logic [6:0] pll0_prediv, pll1_prediv, pll2_prediv, pll3_prediv;
   logic [13:0] pll0_mult;
   logic [11:0] pll1_mult, pll2_mult, pll3_mult;
   logic [5:0] load_cap_eighths;
   logic [7:0] crystal_drive, q;
   logic [1:0] config_error;
   int error_cnt = 0;
   int samples_checked = 0;
   int n;
   wire sda_in = host_sda & ~sda_oe; // Pulled-up open-drain line
   always #50 core_clk = ~core_clk;
   rcs_ref_model ref_u (.core_clk, .run_ref, .run_clk, .ref_line(crystal_or_ref_input),
      .clk_line(clock_only_input));
   rcs_ref_switch dut_u (.core_clk, .rst, .ce, .scl_in, .sda_in, .sda_out, .sda_oe, .crystal_or_ref_input,
      .clock_only_input, .input_select_pin, .shutdown_output_enable_pin, .ref_clk_out, .secondary_in_use,
      .outputs_enabled, .chip_power_down, .pll_power_down, .pll0_prediv, .pll1_prediv, .pll2_prediv,
      .pll3_prediv, .pll0_mult, .pll1_mult, .pll2_mult, .pll3_mult, .load_cap_eighths, .crystal_drive,
      .config_error);
   task automatic cyc(input int k);
      repeat (k) @(posedge core_clk);
   endtask
   // One serial bit, clock high for three core cycles and low for six
   task automatic sbit(input logic b, output logic r);
      host_sda <= b;
      cyc(3);
      scl_in <= 1'b1;
      cyc(2);
      #1 r = sda_in;
      cyc(1);
      scl_in <= 1'b0;
      cyc(3);
   endtask
   task automatic start_c;
      cyc(1);
      host_sda <= 1'b1;
      cyc(3);
      scl_in <= 1'b1;
      cyc(3);
      host_sda <= 1'b0;
      cyc(3);
      scl_in <= 1'b0;
      cyc(3);
   endtask
   task automatic stop_c;
      host_sda <= 1'b0;
      cyc(3);
      scl_in <= 1'b1;
      cyc(3);
      host_sda <= 1'b1;
      cyc(3);
   endtask
   // Byte out MSB first, then the acknowledge slot
   task automatic xfer(input logic [7:0] d, output logic [7:0] r, output logic ack);
      logic b;
      for (int i = 7; i >= 0; i--)
      begin
         sbit(d[i], b);
         r[i] = b;
      end
      sbit(1'b1, ack);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] t;
      logic k1, k2, k3;
      start_c;
      xfer({DEV, 1'b0}, t, k1);
      xfer(a, t, k2);
      xfer(d, t, k3);
      stop_c;
      cyc(4);
      #1 `CHK("write ack", 3'b000, {k1, k2, k3})
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] r);
      logic [7:0] t;
      logic k;
      start_c;
      xfer({DEV, 1'b0}, t, k);
      xfer(a, t, k);
      start_c;
      xfer({DEV, 1'b1}, t, k);
      xfer(8'hff, r, k);
      stop_c;
   endtask
   task automatic wait_sec(input logic v);
      for (int i = 0; i < 200 && secondary_in_use !== v; i++)
      begin
         cyc(1);
         #1;
      end
      `CHK("secondary_in_use", v, secondary_in_use)
      // A wait that ran out ends the run
      if (secondary_in_use !== v)
         give_verdict;
   endtask
   // Counts changes of the selected reference over 24 cycles
   task automatic tog(output int c);
      logic p;
      c = 0;
      #1 p = ref_clk_out;
      repeat (24)
      begin
         cyc(1);
         #1 if (ref_clk_out !== p) c++;
         p = ref_clk_out;
      end
   endtask
   task automatic give_verdict;
      $display("checked %0d mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // Main sequence
   initial
   begin
      cyc(4);
      rst <= 1'b0;
      cyc(4);
      #1 `CHK("pll_power_down", 3'b000, pll_power_down)
      `CHK("pll3_prediv", PREDIV3_RST, pll3_prediv)
      `CHK("pll0_mult", 14'd10, pll0_mult)
      `CHK("pll1_mult", 12'd5, pll1_mult)
      `CHK("pll23_mult", 24'h0050_05, {pll2_mult, pll3_mult})
      `CHK("load_cap_eighths", 6'd28, load_cap_eighths)
      `CHK("crystal_drive", CRYSTAL_DRIVE_CFG_RST, crystal_drive)
      `CHK("outputs_enabled", 1'b0, outputs_enabled)
      cyc(1);
      shutdown_output_enable_pin <= 1'b1;
      cyc(4);
      #1 `CHK("outputs_enabled", 1'b1, outputs_enabled)
      wr(ADR_SD_CFG, 8'h03);
      `CHK("pd and enable", 2'b10, {chip_power_down, outputs_enabled})
      cyc(1);
      shutdown_output_enable_pin <= 1'b0;
      cyc(4);
      #1 `CHK("pd and enable", 2'b01, {chip_power_down, outputs_enabled})
      // Clock enable low holds the decoded pin state
      cyc(1);
      ce <= 1'b0;
      shutdown_output_enable_pin <= 1'b1;
      cyc(4);
      #1 `CHK("frozen enable", 1'b1, outputs_enabled)
      cyc(1);
      ce <= 1'b1;
      cyc(2);
      #1 `CHK("pd and enable", 2'b10, {chip_power_down, outputs_enabled})
      cyc(1);
      shutdown_output_enable_pin <= 1'b0;
      for (int i = 0; i < 3; i++)
         wr(ADR_PREDIV_BASE + 8'(i), 8'h00);
      `CHK("pll_power_down", 3'b111, pll_power_down)
      `CHK("pll12_prediv", 14'h0000, {pll2_prediv, pll1_prediv})
      wr(ADR_PREDIV_BASE, 8'h7f);
      `CHK("pll_power_down", 3'b110, pll_power_down)
      `CHK("pll0_prediv", 7'h7f, pll0_prediv)
      wr(ADR_PREDIV_BASE + 8'h03, 8'h02);
      `CHK("config_error", 2'b10, config_error)
      wr(ADR_PREDIV_BASE + 8'h03, 8'h03);
      `CHK("config_error", 2'b00, config_error)
      wr(ADR_FBLO_BASE, 8'h23);
      wr(ADR_FBHI_BASE, 8'h01);
      wr(ADR_FRAC, 8'h03);
      `CHK("pll0_mult", 14'd586, pll0_mult)
      wr(ADR_FRAC, 8'h00);
      `CHK("pll0_mult", 14'd582, pll0_mult)
      // Fractional count not below feedback count is flagged
      wr(ADR_FBHI_BASE, 8'h00);
      wr(ADR_FBLO_BASE, 8'h03);
      wr(ADR_FRAC, 8'h03);
      `CHK("config_error", 2'b01, config_error)
      `CHK("pll0_mult", 14'd10, pll0_mult)
      wr(ADR_FRAC, 8'h00);
      `CHK("config_error", 2'b00, config_error)
      wr(ADR_FBLO_BASE + 8'h01, 8'hff);
      wr(ADR_FBHI_BASE + 8'h01, 8'h0f);
      `CHK("pll1_mult", 12'hfff, pll1_mult)
      wr(ADR_XLOAD, 8'h1f);
      `CHK("load_cap_eighths", 6'd59, load_cap_eighths)
      wr(ADR_XLOAD, 8'h00);
      rd(ADR_CRYSTAL_DRIVE_CFG, q);
      `CHK("read drive", 8'h11, q)
      rd(8'h40, q);
      `CHK("read unmapped", 8'h00, q)
      for (int m = 0; m < 2; m++)
      begin
         wr(ADR_SRC_FIRST, 8'(2 * m));
         cyc(1);
         input_select_pin <= 1'b1;
         wait_sec(1'b1);
         cyc(1);
         run_ref <= 1'b0;
         tog(n);
         `CHK("clock input feeds", 1'b1, n > 2)
         cyc(1);
         run_ref <= 1'b1;
         input_select_pin <= 1'b0;
         wait_sec(1'b0);
      end
      wr(ADR_SRC_FIRST, 8'h01);
      cyc(1);
      run_ref <= 1'b0;
      tog(n);
      `CHK("clock input primary", 1'b1, n > 2)
      cyc(1);
      run_ref <= 1'b1;
      run_clk <= 1'b0;
      cyc(3);
      tog(n);
      `CHK("ref input unused", 1'b1, n == 0)
      cyc(1);
      run_clk <= 1'b1;
      wr(ADR_SRC_LAST, 8'h04);
      rd(ADR_SRC_FIRST, q);
      `CHK("source alias", 8'h04, q)
      cyc(20);
      #1 `CHK("stay on primary", 1'b0, secondary_in_use)
      cyc(1);
      run_ref <= 1'b0;
      cyc(5);
      #1 `CHK("no early switch", 1'b0, secondary_in_use)
      wait_sec(1'b1);
      tog(n);
      `CHK("secondary feeds", 1'b1, n > 2)
      rd(ADR_STATUS, q);
      `CHK("status lost", 8'h03, q)
      cyc(1);
      run_ref <= 1'b1;
      wait_sec(1'b0);
      give_verdict;
   end
   // Run limit
   initial
   begin
      cyc(90000);
      error_cnt++;
      give_verdict;
   end
endmodule
